/* rtl/uscfc_pkg.sv */
/*
  package for the user scratch and flash write counter register group.
  assumes a 16-bit internal register port addressed by byte address.
*/
`default_nettype none
package uscfc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [6:0]  ADDR_SCRATCH_TWO   = 7'h78;
  localparam logic [6:0]  ADDR_SCRATCH_THREE = 7'h7a;
  localparam logic [6:0]  ADDR_COUNT_LO      = 7'h7c;
  localparam logic [6:0]  ADDR_COUNT_HI      = 7'h7e;
  localparam logic [6:0]  ADDR_GLOBAL_CMD    = 7'h68;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int          CMD_FLASH_UPDATE_BIT = 3;
  localparam int          DIAG_FLASH_FAIL_BIT  = 2;
  localparam logic [15:0] SCRATCH_RESET        = 16'h0000;
  localparam logic [31:0] COUNT_RESET          = 32'h0000_0000;
  localparam logic [15:0] READ_ZERO            = 16'h0000;
  localparam int          WORDS                = 2;
  typedef enum logic [1:0] {
    USCFC_IDLE,
    USCFC_SAVE,
    USCFC_WAIT
  } uscfc_state_t;
endpackage
`default_nettype wire

/* rtl/uscfc_flash_if.sv */
/*
  interface between the register group and its scratch backup store.
  assumes one clock shared by both ends.
*/
`default_nettype none
interface uscfc_flash_if;
  logic        wr;
  logic        addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctrl (output wr, output addr, output wdata, input rdata);
  modport mem  (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* rtl/uscfc_store.sv */
/*
  backup store holding the saved scratch words; registered read data.
  assumes writes come from the register group on the same clock.
*/
`default_nettype none
module uscfc_store
  import uscfc_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rstn_in,
  uscfc_flash_if.mem  port
);
  logic [15:0] mem [WORDS];
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem[0]     <= SCRATCH_RESET;
      mem[1]     <= SCRATCH_RESET;
      port.rdata <= SCRATCH_RESET;
    end else begin
      if (port.wr) begin
        mem[port.addr] <= port.wdata;
      end
      port.rdata <= mem[port.addr];
    end
  end
endmodule
`default_nettype wire

/* rtl/uscfc_top.sv */
/*
  user scratch registers and flash write cycle counter.
  assumes a single-cycle internal register port from the serial engine
  and a flash engine that reports completion and failure pulses.
*/
`default_nettype none
module uscfc_top
  import uscfc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [6:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        flash_done_in,
  input  wire logic        flash_fail_in,
  input  wire logic        data_ready_req_in,
  output logic [15:0]      reg_rdata_out,
  output logic             reg_rvalid_out,
  output logic             flash_start_out,
  output logic             cmd_busy_out,
  output logic             data_ready_pin_out,
  output logic             flash_fail_stat_out
);
  uscfc_flash_if fif();
  uscfc_state_t  state;
  uscfc_state_t  next_state;
  logic [15:0]   user_scratch_two;
  logic [15:0]   user_scratch_three;
  logic [31:0]   write_count;
  logic          busy;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [6:0] a,
                                    input logic [6:0] target);
    return a == target;
  endfunction
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic hit_two    = addr_hit(reg_addr_in, ADDR_SCRATCH_TWO);
  wire logic hit_three  = addr_hit(reg_addr_in, ADDR_SCRATCH_THREE);
  wire logic hit_lo     = addr_hit(reg_addr_in, ADDR_COUNT_LO);
  wire logic hit_hi     = addr_hit(reg_addr_in, ADDR_COUNT_HI);
  wire logic hit_cmd    = addr_hit(reg_addr_in, ADDR_GLOBAL_CMD);
  wire logic accept     = !busy;
  wire logic wr_ok      = reg_wr_in && accept;
  wire logic rd_ok      = reg_rd_in && accept;
  wire logic wr_two     = wr_ok && hit_two;
  wire logic wr_three   = wr_ok && hit_three;
  wire logic cmd_save   = wr_ok && hit_cmd
                          && reg_wdata_in[CMD_FLASH_UPDATE_BIT];
  wire logic write_done = state == USCFC_WAIT && flash_done_in;
  wire logic [15:0] rd_mux =
    hit_two   ? user_scratch_two   :
    hit_three ? user_scratch_three :
    hit_lo    ? write_count[15:0]  :
    hit_hi    ? write_count[31:16] :
    READ_ZERO;
  // ---------------------------------------------------------------
  // backup sequence
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      USCFC_IDLE: if (cmd_save) next_state = USCFC_SAVE;
      USCFC_SAVE: next_state = USCFC_WAIT;
      USCFC_WAIT: if (flash_done_in) next_state = USCFC_IDLE;
    endcase
  end
  assign fif.wr    = state == USCFC_SAVE || cmd_save;
  assign fif.addr  = state == USCFC_SAVE;
  assign fif.wdata = fif.addr ? user_scratch_three : user_scratch_two;
  uscfc_store u_store (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .port    (fif.mem)
  );
  assign busy = state != USCFC_IDLE;
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state              <= USCFC_IDLE;
      user_scratch_two   <= SCRATCH_RESET;
      user_scratch_three <= SCRATCH_RESET;
    end else begin
      state <= next_state;
      if (wr_two) user_scratch_two <= reg_wdata_in;
      if (wr_three) user_scratch_three <= reg_wdata_in;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      write_count <= COUNT_RESET;
    end else if (write_done) begin
      write_count <= write_count + 32'h0000_0001;
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out       <= READ_ZERO;
      reg_rvalid_out      <= 1'b0;
      flash_start_out     <= 1'b0;
      cmd_busy_out        <= 1'b0;
      data_ready_pin_out  <= 1'b0;
      flash_fail_stat_out <= 1'b0;
    end else begin
      reg_rvalid_out     <= rd_ok;
      if (rd_ok) reg_rdata_out <= rd_mux;
      flash_start_out    <= cmd_save;
      cmd_busy_out       <= busy || cmd_save;
      data_ready_pin_out <= data_ready_req_in && !busy;
      if (cmd_save) flash_fail_stat_out <= 1'b0;
      if (write_done)
        flash_fail_stat_out <= flash_fail_in;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_scratch_rw;
    @(posedge clk_in) disable iff (!rstn_in)
    wr_two |=> user_scratch_two == $past(reg_wdata_in);
  endproperty
  a_scratch_rw: assert property (p_scratch_rw)
    else $error("scratch write lost");
  property p_count_step;
    @(posedge clk_in) disable iff (!rstn_in)
    (state == USCFC_WAIT && flash_done_in)
      |=> write_count == $past(write_count) + 32'h0000_0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step by one");
  property p_count_hold;
    @(posedge clk_in) disable iff (!rstn_in)
    !(state == USCFC_WAIT && flash_done_in) |=> $stable(write_count);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("counter moved without flash write");
  property p_lo_read;
    @(posedge clk_in) disable iff (!rstn_in)
    (rd_ok && reg_addr_in == ADDR_COUNT_LO)
      |=> reg_rvalid_out && reg_rdata_out == $past(write_count[15:0]);
  endproperty
  a_lo_read: assert property (p_lo_read)
    else $error("low word read wrong");
  property p_hi_read;
    @(posedge clk_in) disable iff (!rstn_in)
    (rd_ok && reg_addr_in == ADDR_COUNT_HI)
      |=> reg_rdata_out == $past(write_count[31:16]);
  endproperty
  a_hi_read: assert property (p_hi_read)
    else $error("high word read wrong");
  property p_start;
    @(posedge clk_in) disable iff (!rstn_in)
    cmd_save |=> flash_start_out ##1 cmd_busy_out;
  endproperty
  a_start: assert property (p_start)
    else $error("flash update not started");
  property p_busy_quiet;
    @(posedge clk_in) disable iff (!rstn_in)
    busy |=> !reg_rvalid_out && !data_ready_pin_out;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("activity during command");
  property p_fail_flag;
    @(posedge clk_in) disable iff (!rstn_in)
    (state == USCFC_WAIT && flash_done_in && flash_fail_in)
      |=> flash_fail_stat_out;
  endproperty
  a_fail_flag: assert property (p_fail_flag)
    else $error("flash failure not reported");
  property p_three_rw;
    @(posedge clk_in) disable iff (!rstn_in)
    wr_three |=> user_scratch_three == $past(reg_wdata_in);
  endproperty
  a_three_rw: assert property (p_three_rw)
    else $error("second scratch write lost");
  property p_refuse_write;
    @(posedge clk_in) disable iff (!rstn_in)
    (busy && reg_wr_in)
      |=> $stable(user_scratch_two) && $stable(user_scratch_three);
  endproperty
  a_refuse_write: assert property (p_refuse_write)
    else $error("write taken during command");
  property p_no_restart;
    @(posedge clk_in) disable iff (!rstn_in)
    (busy && reg_wr_in) |=> !flash_start_out;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("update restarted during command");
  property p_backup_two;
    @(posedge clk_in) disable iff (!rstn_in)
    (state == USCFC_WAIT && $past(state) == USCFC_WAIT)
      |-> fif.rdata == user_scratch_two;
  endproperty
  a_backup_two: assert property (p_backup_two)
    else $error("scratch word not saved");
  property p_fail_clear;
    @(posedge clk_in) disable iff (!rstn_in)
    cmd_save |=> !flash_fail_stat_out;
  endproperty
  a_fail_clear: assert property (p_fail_clear)
    else $error("stale flash failure shown");
  property p_drdy_follow;
    @(posedge clk_in) disable iff (!rstn_in)
    !busy |=> data_ready_pin_out == $past(data_ready_req_in);
  endproperty
  a_drdy_follow: assert property (p_drdy_follow)
    else $error("data ready not passed on");
endmodule
`default_nettype wire

/* tb/uscfc_flash_model.sv */
/*
  flash engine model: answers a backup start with a done pulse.
  assumes the start pulse arrives on the shared clock.
*/
`default_nettype none
module uscfc_flash_model #(
  parameter int DELAY = 4
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic start_in,
  input  wire logic fail_mode_in,
  output logic      done_out,
  output logic      fail_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // write cycle timer
  // ----------------------------------------------------------------
  int cnt;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt      <= 0;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt == 1);
      if (start_in) cnt <= DELAY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
  // fail only qualifies done
  assign fail_out = done_out & fail_mode_in;
endmodule
`default_nettype wire

/* tb/uscfc_top_tb.sv */
/*
  testbench for the scratch registers and flash write counter.
  assumes the flash engine model answers each backup start.
*/
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module uscfc_top_tb
  import uscfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, wr, rd, drq, fmode, rvalid, start, busy, drp, fstat;
  logic done, fail;
  logic [6:0]  addr;
  logic [15:0] wdata, rdata;
  int bad_count, n_tests, cycles;
  uscfc_top i_dut (.clk_in(clk), .rstn_in(rstn), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .flash_done_in(done), .flash_fail_in(fail), .data_ready_req_in(drq),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .flash_start_out(start), .cmd_busy_out(busy),
    .data_ready_pin_out(drp), .flash_fail_stat_out(fstat));
  uscfc_flash_model i_flash (.clk_in(clk), .rstn_in(rstn),
    .start_in(start), .fail_mode_in(fmode), .done_out(done),
    .fail_out(fail));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask
  task automatic flash(input logic f, input logic [15:0] n);
    fmode = f;
    wr_reg(ADDR_GLOBAL_CMD, 16'h0008);
    `CHK("start", 1'b1, start)
    `CHK("busy", 1'b1, busy)
    `CHK("fail clear", 1'b0, fstat)
    wr_reg(ADDR_SCRATCH_TWO, 16'h0f0f);
    `CHK("drdy busy", 1'b0, drp)
    @(negedge clk);
    rd = 1'b1;
    addr = ADDR_SCRATCH_TWO;
    @(negedge clk);
    rd = 1'b0;
    `CHK("rvalid busy", 1'b0, rvalid)
    for (int i = 0; i < 20 && busy; i++) @(negedge clk);
    `CHK("busy end", 1'b0, busy)
    `CHK("fail stat", f, fstat)
    @(negedge clk);
    `CHK("drdy idle", 1'b1, drp)
    rd_chk(ADDR_COUNT_LO, n);
    rd_chk(ADDR_COUNT_HI, 16'h0000);
    rd_chk(ADDR_SCRATCH_TWO, 16'ha5c3);
  endtask
  // ----------------------------------------------------------------
  // clock, timeout and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 7'h00;
    wdata = 16'h0000;
    drq = 1'b1;
    fmode = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    rd_chk(ADDR_SCRATCH_THREE, SCRATCH_RESET);
    rd_chk(ADDR_COUNT_LO, COUNT_RESET[15:0]);
    wr_reg(ADDR_SCRATCH_TWO, 16'ha5c3);
    wr_reg(ADDR_SCRATCH_THREE, 16'h3c5a);
    wr_reg(ADDR_COUNT_LO, 16'hffff);
    wr_reg(ADDR_COUNT_HI, 16'hffff);
    wr_reg(ADDR_GLOBAL_CMD, 16'hfff7);
    `CHK("no start", 1'b0, start)
    `CHK("no update", 1'b0, busy)
    rd_chk(ADDR_SCRATCH_TWO, 16'ha5c3);
    rd_chk(ADDR_SCRATCH_THREE, 16'h3c5a);
    rd_chk(ADDR_COUNT_LO, 16'h0000);
    rd_chk(ADDR_COUNT_HI, 16'h0000);
    rd_chk(7'h10, READ_ZERO);
    drq = 1'b0;
    @(negedge clk);
    `CHK("drdy off", 1'b0, drp)
    drq = 1'b1;
    flash(1'b0, 16'h0001);
    flash(1'b1, 16'h0002);
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    `CHK("fail reset", 1'b0, fstat)
    rd_chk(ADDR_SCRATCH_TWO, SCRATCH_RESET);
    rd_chk(ADDR_COUNT_LO, COUNT_RESET[15:0]);
    wr_reg(ADDR_SCRATCH_TWO, 16'ha5c3);
    flash(1'b1, 16'h0001);
    flash(1'b0, 16'h0002);
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
